/* design/wake_ctl_pkg.sv */
// constants for the wake-up control float and miscellaneous registers
package wake_ctl_pkg;

    // register offsets
    localparam logic [7:0] FLOAT_OFFSET     = 8'h07;
    localparam logic [7:0] MISC_OFFSET      = 8'h08;

    // reset values
    localparam logic [7:0] FLOAT_RESET      = 8'h00;
    localparam logic [7:0] MISC_RESET       = 8'h00;

    // module_output_float field positions
    localparam int FLOAT_FLOPPY_BIT         = 0;
    localparam int FLOAT_PARALLEL_BIT       = 1;
    localparam int FLOAT_SERIAL_B_BIT       = 2;
    localparam int FLOAT_SERIAL_A_BIT       = 3;
    localparam int FLOAT_KBD_MOUSE_BIT      = 4;
    localparam int MODULE_GROUPS            = 5;
    localparam logic [7:0] FLOAT_WMASK      = 8'h1f;

    // wake_misc_control field positions
    localparam int MISC_SWAP_BIT            = 0;
    localparam int MISC_TIMEOUT_FLAG_BIT    = 4;
    localparam int MISC_OVERRIDE_FLAG_BIT   = 5;
    localparam int MISC_ON_REQ_BIT          = 6;
    localparam int MISC_OFF_REQ_BIT         = 7;

    // timing
    localparam int CLK_KHZ                  = 125000;
    localparam int OVERRIDE_TIME_MS         = 4000;
    localparam int HALF_SECOND_MS           = 500;
    localparam int OVERRIDE_CYCLES          = OVERRIDE_TIME_MS * CLK_KHZ;
    localparam int HALF_SECOND_CYCLES       = HALF_SECOND_MS * CLK_KHZ;
    localparam int TIMER_WIDTH              = 32;

    // crowbar timeout in half seconds per select code
    localparam logic [7:0] CROWBAR_HALVES [8] = '{
        8'h01, 8'h02, 8'h04, 8'h06, 8'h0c, 8'h14, 8'h1e, 8'h28
    };

endpackage : wake_ctl_pkg

/* design/sync_two_flop.sv */
// two-flop synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none

module sync_two_flop #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule // sync_two_flop

`default_nettype wire

/* design/hold_timer.sv */
// counts cycles a condition holds, pulses once when the limit is reached
`timescale 1ns/1ps
`default_nettype none

module hold_timer #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset,
    // condition and limit
    input  wire logic             run,
    input  wire logic [WIDTH-1:0] limit,
    output var  logic             expired
);

    logic [WIDTH-1:0] count_r;
    logic             done_r;

    // one pulse per hold; dropping run rearms the timer
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            count_r <= '0;
            done_r  <= 1'b0;
            expired <= 1'b0;
        end else if (!run) begin
            count_r <= '0;
            done_r  <= 1'b0;
            expired <= 1'b0;
        end else if (!done_r && count_r + 1'b1 >= limit) begin
            count_r <= count_r;
            done_r  <= 1'b1;
            expired <= 1'b1;
        end else begin
            count_r <= done_r ? count_r : count_r + 1'b1;
            expired <= 1'b0;
        end
    end

endmodule // hold_timer

`default_nettype wire

/* design/wake_ctl_float_and_misc_regs.sv */
// wake-up unit output-float and miscellaneous control registers
`timescale 1ns/1ps
`default_nettype none

// Operation
// - float bit acts only on a disabled module
// - float register resets to zero
// - float register at 07h, bits 7-5 reserved
// - bit 4: keyboard/mouse group
// - bit 3: first serial port
// - bit 2: second serial port
// - bit 1: parallel port
// - bit 0: floppy controller
// - misc register at 08h, resets zero, bits 3-1 reserved
// - bit 7 write 1 sets software-off flag, reads zero
// - bit 6 write 1 sets software-on flag, reads zero
// - main power not good: only management bus writes bit 6
// - button held over 4 s sets bit 5, supply off
// - crowbar timeout sets bit 4, supply off
// - bits 5, 4: write 1 clears, else hold
// - bit 0 exchanges keyboard and mouse lines
// - fast-disable forces disabled, else activation bit
// - enabled request writes raise management interrupt
module wake_ctl_float_and_misc_regs
    import wake_ctl_pkg::*;
#(
    parameter int OVERRIDE_LIMIT = OVERRIDE_CYCLES,
    parameter int HALF_SEC_LIMIT = HALF_SECOND_CYCLES
) (
    // clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     reset,
    // register access
    input  wire logic [7:0]               reg_addr,
    input  wire logic                     reg_write,
    input  wire logic                     reg_read,
    input  wire logic                     reg_from_mgmt,
    input  wire logic [7:0]               reg_wdata,
    output var  logic [7:0]               reg_rdata,
    // module state from configuration logic
    input  wire logic [MODULE_GROUPS-1:0] fast_module_disable,
    input  wire logic [MODULE_GROUPS-1:0] module_active,
    input  wire logic [MODULE_GROUPS-1:0] module_cfg_float,
    output var  logic [MODULE_GROUPS-1:0] module_float,
    // power control pins and settings
    input  wire logic                     main_power_good,
    input  wire logic                     power_button_n,
    input  wire logic [2:0]               crowbar_timeout_sel,
    output var  logic                     main_supply_on,
    // event status
    input  wire logic                     software_on_irq_enable,
    input  wire logic                     software_off_irq_enable,
    input  wire logic                     software_on_flag_clear,
    input  wire logic                     software_off_flag_clear,
    output var  logic                     software_on_flag,
    output var  logic                     software_off_flag,
    output var  logic                     mgmt_irq,
    // keyboard and mouse pins, open drain
    input  wire logic                     kbd_clock_line_in,
    input  wire logic                     kbd_data_line_in,
    input  wire logic                     mouse_clock_line_in,
    input  wire logic                     mouse_data_line_in,
    output var  logic                     kbd_clock_line_oe_n,
    output var  logic                     kbd_data_line_oe_n,
    output var  logic                     mouse_clock_line_oe_n,
    output var  logic                     mouse_data_line_oe_n,
    output var  logic                     kbd_clock_line_out,
    output var  logic                     kbd_data_line_out,
    output var  logic                     mouse_clock_line_out,
    output var  logic                     mouse_data_line_out,
    // keyboard controller side
    input  wire logic                     ctl_kbd_clock_pull,
    input  wire logic                     ctl_kbd_data_pull,
    input  wire logic                     ctl_mouse_clock_pull,
    input  wire logic                     ctl_mouse_data_pull,
    output var  logic                     ctl_kbd_clock,
    output var  logic                     ctl_kbd_data,
    output var  logic                     ctl_mouse_clock,
    output var  logic                     ctl_mouse_data
);

    // register state
    logic [4:0] float_bits_r;
    logic       kbd_mouse_swap_r;
    logic       button_override_flag_r;
    logic       supply_timeout_flag_r;
    logic       crowbar_armed_r;

    // synchronised pins
    logic [5:0] pins_sync;
    logic       power_good_s;
    logic       button_held_s;
    logic       kbd_clk_s;
    logic       kbd_dat_s;
    logic       mouse_clk_s;
    logic       mouse_dat_s;

    // decode
    logic float_hit;
    logic misc_hit;
    logic float_wr;
    logic misc_wr;
    logic on_req_wr;
    logic off_req_wr;
    logic on_req_ok;
    logic override_hit;
    logic timeout_hit;
    logic [TIMER_WIDTH-1:0] crowbar_limit;
    logic [MODULE_GROUPS-1:0] module_disabled;

    // pins pass two flops first
    sync_two_flop #(
        .WIDTH (6)
    ) u_pin_sync (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .async_in ({main_power_good, ~power_button_n, kbd_clock_line_in,
                    kbd_data_line_in, mouse_clock_line_in, mouse_data_line_in}),
        .sync_out (pins_sync)
    );

    assign power_good_s  = pins_sync[5];
    assign button_held_s = pins_sync[4];
    assign kbd_clk_s     = pins_sync[3];
    assign kbd_dat_s     = pins_sync[2];
    assign mouse_clk_s   = pins_sync[1];
    assign mouse_dat_s   = pins_sync[0];

    // bank ignored
    assign float_hit  = (reg_addr == FLOAT_OFFSET);
    assign misc_hit   = (reg_addr == MISC_OFFSET);
    assign float_wr   = reg_write && float_hit;
    assign misc_wr    = reg_write && misc_hit;
    assign off_req_wr = misc_wr && reg_wdata[MISC_OFF_REQ_BIT];
    assign on_req_wr  = misc_wr && reg_wdata[MISC_ON_REQ_BIT];

    // host cannot power up a dead board
    assign on_req_ok  = on_req_wr && (power_good_s || reg_from_mgmt);

    // fast-disabled or inactive
    assign module_disabled = fast_module_disable | ~module_active;

    // crowbar limit
    assign crowbar_limit = TIMER_WIDTH'(CROWBAR_HALVES[crowbar_timeout_sel])
                         * TIMER_WIDTH'(HALF_SEC_LIMIT);

    // output-float register
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            float_bits_r <= FLOAT_RESET[4:0];
        end else if (float_wr) begin
            float_bits_r <= reg_wdata[4:0] & FLOAT_WMASK[4:0];
        end
    end

    // float bit acts on disabled groups only
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            module_float <= '0;
        end else begin
            for (int i = 0; i < MODULE_GROUPS; i++) begin
                module_float[i] <= module_cfg_float[i]
                                 | (float_bits_r[i] & module_disabled[i]);
            end
        end
    end
    // bit-to-group map: 4 kbd/mouse 3 serial a 2 serial b
    // 1 parallel 0 floppy

    // swap control
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            kbd_mouse_swap_r <= MISC_RESET[MISC_SWAP_BIT];
        end else if (misc_wr) begin
            kbd_mouse_swap_r <= reg_wdata[MISC_SWAP_BIT];
        end
    end

    // override timer
    hold_timer #(
        .WIDTH (TIMER_WIDTH)
    ) u_override_timer (
        .sys_clk (sys_clk),
        .reset   (reset),
        .run     (button_held_s),
        .limit   (TIMER_WIDTH'(OVERRIDE_LIMIT)),
        .expired (override_hit)
    );

    // crowbar: on requested, power never good
    hold_timer #(
        .WIDTH (TIMER_WIDTH)
    ) u_crowbar_timer (
        .sys_clk (sys_clk),
        .reset   (reset),
        .run     (crowbar_armed_r && !power_good_s),
        .limit   (crowbar_limit),
        .expired (timeout_hit)
    );

    // armed by accepted on-request, dropped at power good
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            crowbar_armed_r <= 1'b0;
        end else if (on_req_ok) begin
            crowbar_armed_r <= 1'b1;
        end else if (power_good_s || timeout_hit || override_hit) begin
            crowbar_armed_r <= 1'b0;
        end
    end

    // sticky flags; event beats clear
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            button_override_flag_r <= MISC_RESET[MISC_OVERRIDE_FLAG_BIT];
        end else if (override_hit) begin
            button_override_flag_r <= 1'b1;
        end else if (misc_wr && reg_wdata[MISC_OVERRIDE_FLAG_BIT]) begin
            button_override_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            supply_timeout_flag_r <= MISC_RESET[MISC_TIMEOUT_FLAG_BIT];
        end else if (timeout_hit) begin
            supply_timeout_flag_r <= 1'b1;
        end else if (misc_wr && reg_wdata[MISC_TIMEOUT_FLAG_BIT]) begin
            supply_timeout_flag_r <= 1'b0;
        end
    end

    // forced off beats any request
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            main_supply_on <= 1'b0;
        end else if (override_hit || timeout_hit) begin
            main_supply_on <= 1'b0;
        end else if (off_req_wr) begin
            main_supply_on <= 1'b0;
        end else if (on_req_ok) begin
            main_supply_on <= 1'b1;
        end
    end

    // request flags; set beats clear
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            software_off_flag <= 1'b0;
        end else if (off_req_wr) begin
            software_off_flag <= 1'b1;
        end else if (software_off_flag_clear) begin
            software_off_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            software_on_flag <= 1'b0;
        end else if (on_req_ok) begin
            software_on_flag <= 1'b1;
        end else if (software_on_flag_clear) begin
            software_on_flag <= 1'b0;
        end
    end

    // one-cycle pulse per enabled request
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            mgmt_irq <= 1'b0;
        end else begin
            mgmt_irq <= (on_req_ok && software_on_irq_enable)
                      || (off_req_wr && software_off_irq_enable);
        end
    end

    // request and reserved bits read zero
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_read && float_hit) begin
            reg_rdata <= {3'h0, float_bits_r};
        end else if (reg_read && misc_hit) begin
            reg_rdata <= {2'h0, button_override_flag_r, supply_timeout_flag_r,
                          3'h0, kbd_mouse_swap_r};
        end else if (reg_read) begin
            reg_rdata <= 8'h00;
        end
    end

    // line exchange toward the controller
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            {ctl_kbd_clock, ctl_kbd_data, ctl_mouse_clock, ctl_mouse_data} <= 4'hf;
        end else if (kbd_mouse_swap_r) begin
            {ctl_kbd_clock, ctl_kbd_data}     <= {mouse_clk_s, mouse_dat_s};
            {ctl_mouse_clock, ctl_mouse_data} <= {kbd_clk_s, kbd_dat_s};
        end else begin
            {ctl_kbd_clock, ctl_kbd_data}     <= {kbd_clk_s, kbd_dat_s};
            {ctl_mouse_clock, ctl_mouse_data} <= {mouse_clk_s, mouse_dat_s};
        end
    end

    // pins: enable low pulls low; a floated kbd/mouse group releases all four lines
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            kbd_clock_line_oe_n   <= 1'b1;
            kbd_data_line_oe_n    <= 1'b1;
            mouse_clock_line_oe_n <= 1'b1;
            mouse_data_line_oe_n  <= 1'b1;
        end else if (module_float[FLOAT_KBD_MOUSE_BIT]) begin
            kbd_clock_line_oe_n   <= 1'b1;
            kbd_data_line_oe_n    <= 1'b1;
            mouse_clock_line_oe_n <= 1'b1;
            mouse_data_line_oe_n  <= 1'b1;
        end else if (kbd_mouse_swap_r) begin
            kbd_clock_line_oe_n   <= ~ctl_mouse_clock_pull;
            kbd_data_line_oe_n    <= ~ctl_mouse_data_pull;
            mouse_clock_line_oe_n <= ~ctl_kbd_clock_pull;
            mouse_data_line_oe_n  <= ~ctl_kbd_data_pull;
        end else begin
            kbd_clock_line_oe_n   <= ~ctl_kbd_clock_pull;
            kbd_data_line_oe_n    <= ~ctl_kbd_data_pull;
            mouse_clock_line_oe_n <= ~ctl_mouse_clock_pull;
            mouse_data_line_oe_n  <= ~ctl_mouse_data_pull;
        end
    end

    // open drain only ever drives low
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            kbd_clock_line_out   <= 1'b0;
            kbd_data_line_out    <= 1'b0;
            mouse_clock_line_out <= 1'b0;
            mouse_data_line_out  <= 1'b0;
        end
    end

endmodule // wake_ctl_float_and_misc_regs

`default_nettype wire

/* tb/wake_ctl_props.sv */
// port-level assertions for the float and miscellaneous registers
`timescale 1ns/1ps
`default_nettype none

module wake_ctl_props
    import wake_ctl_pkg::*;
(
    // clock and reset
    input wire logic                     sys_clk,
    input wire logic                     reset,
    // register access
    input wire logic [7:0]               reg_addr,
    input wire logic                     reg_write,
    input wire logic                     reg_read,
    input wire logic                     reg_from_mgmt,
    input wire logic [7:0]               reg_wdata,
    input wire logic [7:0]               reg_rdata,
    // module state
    input wire logic [MODULE_GROUPS-1:0] fast_module_disable,
    input wire logic [MODULE_GROUPS-1:0] module_active,
    input wire logic [MODULE_GROUPS-1:0] module_cfg_float,
    input wire logic [MODULE_GROUPS-1:0] module_float,
    // power and events
    input wire logic                     main_supply_on,
    input wire logic                     software_off_irq_enable,
    input wire logic                     software_on_flag,
    input wire logic                     software_off_flag,
    input wire logic                     mgmt_irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    logic                     misc_wr;
    logic [MODULE_GROUPS-1:0] clean_r;
    logic [MODULE_GROUPS-1:0] cfg_r;

    assign misc_wr = reg_write && reg_addr == MISC_OFFSET;

    // cleared in reset: no false fire after release
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            clean_r <= '0;
            cfg_r   <= '0;
        end else begin
            clean_r <= ~fast_module_disable & module_active & ~module_cfg_float;
            cfg_r   <= module_cfg_float;
        end
    end

    a_enabled_no_float: assert property ((module_float & clean_r) == '0)
        else $error("enabled module floated");
    a_cfg_governs: assert property ((cfg_r & ~module_float) == '0)
        else $error("config float bit ignored");
    a_unmapped_reads_zero: assert property (reg_read && reg_addr != FLOAT_OFFSET
        && reg_addr != MISC_OFFSET |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_float_reserved_zero: assert property (reg_read && reg_addr == FLOAT_OFFSET
        |=> reg_rdata[7:5] == 3'h0)
        else $error("float reserved bits set");
    a_misc_reads_zero: assert property (reg_read && reg_addr == MISC_OFFSET
        |=> (reg_rdata & 8'hce) == 8'h00)
        else $error("misc request or reserved bits set");
    a_on_request_flag: assert property (misc_wr && reg_wdata[MISC_ON_REQ_BIT]
        && reg_from_mgmt |=> software_on_flag)
        else $error("on request lost");
    a_off_request_flag: assert property (misc_wr && reg_wdata[MISC_OFF_REQ_BIT]
        |=> software_off_flag && !main_supply_on)
        else $error("off request lost");
    a_off_irq_raised: assert property (misc_wr && reg_wdata[MISC_OFF_REQ_BIT]
        && software_off_irq_enable |=> mgmt_irq)
        else $error("off irq missing");
    a_irq_has_cause: assert property (mgmt_irq |-> $past(misc_wr))
        else $error("irq without request write");

    c_on_request: cover property (misc_wr && reg_wdata[MISC_ON_REQ_BIT] ##1 main_supply_on);
    c_off_irq: cover property (misc_wr ##1 mgmt_irq && software_off_flag);
    c_float_read: cover property (reg_read && reg_addr == FLOAT_OFFSET);
endmodule // wake_ctl_props

`default_nettype wire

/* tb/tb.sv */
// self-checking testbench for the float and miscellaneous registers
`timescale 1ns/1ps
`default_nettype none

module tb;
    import wake_ctl_pkg::*;
    localparam int OVR  = 20;
    localparam int HALF = 4;

    logic       sys_clk, reset, reg_write, reg_read, reg_from_mgmt;
    logic       main_power_good, power_button_n, on_en, off_en, on_clr, off_clr;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [4:0] fast, active, cfg, module_float;
    logic [2:0] tsel;
    logic       main_supply_on, software_on_flag, software_off_flag, mgmt_irq;
    // lines: kbd clock, kbd data, mouse clock, mouse data
    logic [3:0] pull, tb_low, ctl_v, oe_n_v, out_v, lvl;
    int         fail_count, cmp_count;

    // pulled-up open drain
    assign lvl = ~tb_low & (oe_n_v | out_v);

    wake_ctl_float_and_misc_regs #(.OVERRIDE_LIMIT(OVR), .HALF_SEC_LIMIT(HALF)) u_dut (
        .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_write(reg_write),
        .reg_read(reg_read), .reg_from_mgmt(reg_from_mgmt), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .fast_module_disable(fast), .module_active(active),
        .module_cfg_float(cfg), .module_float(module_float), .main_power_good(main_power_good),
        .power_button_n(power_button_n), .crowbar_timeout_sel(tsel),
        .main_supply_on(main_supply_on), .software_on_irq_enable(on_en),
        .software_off_irq_enable(off_en), .software_on_flag_clear(on_clr),
        .software_off_flag_clear(off_clr), .software_on_flag(software_on_flag),
        .software_off_flag(software_off_flag), .mgmt_irq(mgmt_irq),
        .kbd_clock_line_in(lvl[3]), .kbd_data_line_in(lvl[2]),
        .mouse_clock_line_in(lvl[1]), .mouse_data_line_in(lvl[0]),
        .kbd_clock_line_oe_n(oe_n_v[3]), .kbd_data_line_oe_n(oe_n_v[2]),
        .mouse_clock_line_oe_n(oe_n_v[1]), .mouse_data_line_oe_n(oe_n_v[0]),
        .kbd_clock_line_out(out_v[3]), .kbd_data_line_out(out_v[2]),
        .mouse_clock_line_out(out_v[1]), .mouse_data_line_out(out_v[0]),
        .ctl_kbd_clock_pull(pull[3]), .ctl_kbd_data_pull(pull[2]),
        .ctl_mouse_clock_pull(pull[1]), .ctl_mouse_data_pull(pull[0]),
        .ctl_kbd_clock(ctl_v[3]), .ctl_kbd_data(ctl_v[2]),
        .ctl_mouse_clock(ctl_v[1]), .ctl_mouse_data(ctl_v[0]));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic step(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d, logic m);
        @(posedge sys_clk);
        reg_addr      <= a;
        reg_wdata     <= d;
        reg_from_mgmt <= m;
        reg_write     <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
        #1;
    endtask

    task automatic rd(logic [7:0] a, logic [7:0] exp, string name);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1;
        check(name, reg_rdata, exp);
    endtask

    task automatic grp(logic [4:0] f, logic [4:0] a, logic [4:0] c);
        @(posedge sys_clk);
        fast   <= f;
        active <= a;
        cfg    <= c;
        step(1);
    endtask

    // bounded so a stuck supply cannot hang
    task automatic wait_off(output int n);
        n = 0;
        while (main_supply_on === 1'b1 && n < 200) begin
            step(1);
            n++;
        end
    endtask

    task automatic t_reset();
        rd(FLOAT_OFFSET, FLOAT_RESET, "float reset");
        rd(MISC_OFFSET, MISC_RESET, "misc reset");
        check("float outputs reset", module_float, 8'h00);
    endtask

    task automatic t_float();
        wr(FLOAT_OFFSET, 8'hff, 1'b0);
        rd(FLOAT_OFFSET, 8'h1f, "float reserved");
        wr(8'h05, 8'h00, 1'b0);
        rd(FLOAT_OFFSET, 8'h1f, "unmapped write");
        rd(8'h05, 8'h00, "unmapped read");
        wr(MISC_OFFSET, 8'h0e, 1'b0);
        rd(MISC_OFFSET, 8'h00, "misc reserved");
        for (int i = 0; i < MODULE_GROUPS; i++) begin
            grp(5'h00, 5'h1f, 5'h00);
            check("enabled no float", module_float, 8'h00);
            grp(5'h01 << i, 5'h1f, 5'h00);
            check("fast disable floats", module_float, 8'h01 << i);
            grp(5'h00, ~(5'h01 << i), 5'h00);
            check("inactive floats", module_float, 8'h01 << i);
        end
        wr(FLOAT_OFFSET, 8'h00, 1'b0);
        grp(5'h1f, 5'h00, 5'h00);
        check("float bit clear", module_float, 8'h00);
        grp(5'h00, 5'h1f, 5'h1f);
        check("config governs", module_float, 8'h1f);
    endtask

    task automatic t_swap();
        int e;
        grp(5'h00, 5'h1f, 5'h00);
        for (int s = 0; s < 2; s++) begin
            wr(MISC_OFFSET, 8'(s), 1'b0);
            for (int j = 0; j < 4; j++) begin
                e = (s == 1) ? j ^ 2 : j;
                @(posedge sys_clk);
                pull <= 4'h1 << j;
                step(2);
                check("pull to pin", oe_n_v, 4'(~(4'h1 << e)));
                check("line out low", out_v, 8'h00);
                @(posedge sys_clk);
                pull   <= 4'h0;
                tb_low <= 4'h1 << j;
                step(4);
                check("pin to ctl", ctl_v, 4'(~(4'h1 << e)));
                @(posedge sys_clk);
                tb_low <= 4'h0;
            end
        end
        wr(FLOAT_OFFSET, 8'h10, 1'b0);
        grp(5'h10, 5'h1f, 5'h00);
        @(posedge sys_clk);
        pull <= 4'hf;
        step(2);
        check("kbd float releases", oe_n_v, 8'h0f);
        @(posedge sys_clk);
        pull <= 4'h0;
    endtask

    task automatic t_crowbar();
        int n;
        wr(MISC_OFFSET, 8'h40, 1'b0);
        check("host on refused", {software_on_flag, main_supply_on, mgmt_irq}, 8'h00);
        wr(MISC_OFFSET, 8'h40, 1'b1);
        check("mgmt on", {software_on_flag, main_supply_on, mgmt_irq}, 8'h07);
        wait_off(n);
        check("crowbar time", 8'(n >= HALF - 1 && n < 200), 8'h01);
        rd(MISC_OFFSET, 8'h10, "crowbar flag");
        wr(MISC_OFFSET, 8'h00, 1'b0);
        rd(MISC_OFFSET, 8'h10, "zero keeps flag");
        wr(MISC_OFFSET, 8'h10, 1'b0);
        rd(MISC_OFFSET, 8'h00, "one clears flag");
    endtask

    task automatic t_off();
        @(posedge sys_clk);
        main_power_good <= 1'b1;
        on_clr          <= 1'b1;
        @(posedge sys_clk);
        on_clr <= 1'b0;
        step(4);
        check("on flag cleared", software_on_flag, 8'h00);
        wr(MISC_OFFSET, 8'h40, 1'b0);
        check("host on powered", main_supply_on, 8'h01);
        wr(MISC_OFFSET, 8'h80, 1'b0);
        check("off request", {software_off_flag, main_supply_on, mgmt_irq}, 8'h05);
        rd(MISC_OFFSET, 8'h00, "request bits clear");
        @(posedge sys_clk);
        off_en <= 1'b0;
        wr(MISC_OFFSET, 8'h80, 1'b0);
        check("masked irq", mgmt_irq, 8'h00);
    endtask

    task automatic t_override();
        int n;
        wr(MISC_OFFSET, 8'h40, 1'b0);
        @(posedge sys_clk);
        power_button_n <= 1'b0;
        wait_off(n);
        check("override time", 8'(n >= OVR && n < 200), 8'h01);
        @(posedge sys_clk);
        power_button_n <= 1'b1;
        rd(MISC_OFFSET, 8'h20, "override flag");
        wr(MISC_OFFSET, 8'h20, 1'b0);
        rd(MISC_OFFSET, 8'h00, "override cleared");
    endtask

    initial begin
        reset = 1'b1;
        {reg_write, reg_read, reg_from_mgmt, main_power_good, on_clr, off_clr} = '0;
        {power_button_n, on_en, off_en} = 3'h7;
        {reg_addr, reg_wdata} = '0;
        {fast, active, cfg, tsel} = '0;
        {pull, tb_low} = '0;
        fail_count = 0;
        cmp_count = 0;
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        step(4);
        t_reset();
        t_float();
        t_swap();
        t_crowbar();
        t_off();
        t_override();
        results();
    end

    initial begin
        #200000;
        fail_count++;
        results();
    end
endmodule // tb

bind wake_ctl_float_and_misc_regs wake_ctl_props u_props (
    .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_read(reg_read), .reg_from_mgmt(reg_from_mgmt), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .fast_module_disable(fast_module_disable),
    .module_active(module_active), .module_cfg_float(module_cfg_float),
    .module_float(module_float), .main_supply_on(main_supply_on),
    .software_off_irq_enable(software_off_irq_enable), .software_on_flag(software_on_flag),
    .software_off_flag(software_off_flag), .mgmt_irq(mgmt_irq));

`default_nettype wire
